// [core/mtsio_pkg.sv]
// Constants, register map and field codes for the motion task select I/O block
package mtsio_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned N_IN     = 14;
  localparam int unsigned N_OUT    = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned FN_W     = 4;
  localparam int unsigned SYNC_W   = 24;
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned CNT_W    = 20;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_INMAP0 = 8'h04;
  localparam logic [7:0] REG_INMAP1 = 8'h08;
  localparam logic [7:0] REG_OUTMAP = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // ==========================================================================
  // Control bits
  localparam int unsigned CTRL_BASE_HOME = 0;
  localparam int unsigned CTRL_BASE_NEXT = 1;
  localparam int unsigned CTRL_VIOL_CLR  = 2;
  localparam logic [1:0]  CTRL_RST       = 2'h0;

  // ==========================================================================
  // Status fields
  localparam int unsigned ST_CARD_LSB  = 0;
  localparam int unsigned ST_BASE_HOME = 14;
  localparam int unsigned ST_BASE_NEXT = 15;
  localparam int unsigned ST_BLK_LSB   = 16;
  localparam int unsigned ST_FOLLOW    = 24;
  localparam int unsigned ST_RESP      = 25;
  localparam int unsigned ST_FAULT     = 26;
  localparam int unsigned ST_VIOL      = 27;
  localparam int unsigned ST_PEND      = 28;
  localparam int unsigned ST_JOG       = 29;

  // ==========================================================================
  // Input function codes; address bit k uses code FN_ADDR0 + k
  localparam logic [3:0] FN_ADDR0 = 4'h0;
  localparam logic [3:0] FN_HOME  = 4'h8;
  localparam logic [3:0] FN_CLEAR = 4'h9;
  localparam logic [3:0] FN_NEXT  = 4'hA;
  localparam logic [3:0] FN_JOG   = 4'hB;
  localparam logic [3:0] FN_START = 4'hC;
  localparam logic [3:0] FN_NONE  = 4'hF;
  localparam logic [55:0] INMAP_RST = 56'hCFBA9876543210;

  // ==========================================================================
  // Output source codes
  localparam logic [3:0] SRC_TARGET_REACHED_OUTPUT  = 4'h0;
  localparam logic [3:0] SRC_FERR   = 4'h1;
  localparam logic [3:0] SRC_FOLLOW = 4'h2;
  localparam logic [3:0] SRC_RESP   = 4'h3;
  localparam logic [3:0] SRC_JOG    = 4'h4;
  localparam logic [3:0] SRC_PEND   = 4'h5;
  localparam logic [3:0] SRC_FAULT  = 4'h6;
  localparam logic [31:0] OUTMAP_RST = 32'hFFFFFF10;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned ADDR_HOLD_MS  = 4;
  localparam int unsigned START_MAX_MS  = 2;
  localparam int unsigned OUT_RESP_MS   = 10;
  localparam int unsigned ADDR_HOLD_CYC = ADDR_HOLD_MS * CYC_PER_MS;
  localparam int unsigned START_MAX_CYC = START_MAX_MS * CYC_PER_MS;
  localparam int unsigned OUT_RESP_CYC  = OUT_RESP_MS * CYC_PER_MS;

endpackage

// [core/mtsio_sync_if.sv]
// Raw and filtered input vectors between the top and the input filter
`timescale 1ns/1ps
`default_nettype none
interface mtsio_sync_if;
  logic [mtsio_pkg::SYNC_W-1:0] raw;
  logic [mtsio_pkg::SYNC_W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// [core/mtsio_sync.sv]
// Three-stage synchroniser and agreement filter for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module mtsio_sync (
  input wire logic    clk_i,
  input wire logic    rst_i,
  mtsio_sync_if.filt  sif
);
  import mtsio_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] clean;
  } mtsio_sync_st_t;

  mtsio_sync_st_t r_reg;
  mtsio_sync_st_t r_next;

  // ==========================================================================
  // Filter: a bit changes only once stages two and three agree
  always_comb begin
    r_next       = r_reg;
    r_next.s1    = sif.raw;
    r_next.s2    = r_reg.s1;
    r_next.s3    = r_reg.s2;
    r_next.clean = (r_reg.s2 & r_reg.s3) | (r_reg.clean & (r_reg.s2 ^ r_reg.s3));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.clean = r_reg.clean;
endmodule
`default_nettype wire

// [core/mtsio_top.sv]
// Motion task select I/O: configurable inputs and outputs with Wishbone setup
// Summary of operation
// - Fourteen digital inputs and eight digital outputs, each with a selectable function.
// - Pin functions are defaults only; software may reassign each pin's function.
// - Eight address inputs form an unsigned block number, first input is LSB.
// - After a valid start, the selected task begins within two ms.
// - Each output follows its internal condition within ten ms.
// - Card home input is ignored when a base-unit input serves as home.
// - Error-clear input clears the follow fault and response monitor warnings.
// - Next-task start launches follow-on task only once target position is reached.
// - A configured base-unit input may also request the next task.
// - Jog rising edge starts jog motion; falling edge cancels it.
// - Output fault flag rises when any card output is overloaded or shorted.
// - Start launches the addressed task, or homing when no task is addressed.
// - Target reached output is high once axis is inside target window.
// - Following error output is low while deviation is outside its window.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module mtsio_top #(
  parameter int unsigned ADDR_HOLD_CYC   = mtsio_pkg::ADDR_HOLD_CYC,
  parameter int unsigned START_LIMIT_CYC = mtsio_pkg::START_MAX_CYC,
  parameter int unsigned OUT_LIMIT_CYC   = mtsio_pkg::OUT_RESP_CYC
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [mtsio_pkg::WB_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic [mtsio_pkg::N_IN-1:0]      card_in_i,
  input  wire logic                            base_home_i,
  input  wire logic                            base_next_i,
  input  wire logic [mtsio_pkg::N_OUT-1:0]     out_fault_i,
  input  wire logic                            in_window_i,
  input  wire logic                            ferr_outside_i,
  input  wire logic                            follow_evt_i,
  input  wire logic                            resp_evt_i,
  output logic      [mtsio_pkg::N_OUT-1:0]     card_out_o,
  output logic                                 out_fault_o,
  output logic                                 task_start_o,
  output logic                                 homing_start_o,
  output logic      [mtsio_pkg::ADDR_W-1:0]    task_num_o,
  output logic                                 next_task_o,
  output logic                                 jog_start_o,
  output logic                                 jog_cancel_o,
  output logic                                 jog_active_o,
  output logic                                 home_switch_o
);
  import mtsio_pkg::*;

  typedef struct packed {
    logic                       ack;
    logic [31:0]                dat;
    logic [1:0]                 ctrl;
    logic [N_IN-1:0][FN_W-1:0]  inmap;
    logic [N_OUT-1:0][FN_W-1:0] outmap;
    logic                       p_start;
    logic                       p_next;
    logic                       p_jog;
    logic                       p_clear;
    logic [ADDR_W-1:0]          blk;
    logic [ADDR_W-1:0]          addr_prev;
    logic [CNT_W-1:0]           addr_age;
    logic                       viol;
    logic                       pend;
    logic                       fw;
    logic                       rw;
    logic                       t_start;
    logic                       h_start;
    logic                       nxt;
    logic                       jog_s;
    logic                       jog_c;
    logic                       jog_a;
    logic                       home;
    logic                       fault;
    logic [N_OUT-1:0]           outs;
    logic [CNT_W-1:0]           lat_cnt;
    logic [CNT_W-1:0]           out_lag;
  } mtsio_st_t;

  mtsio_st_t r_reg;
  mtsio_st_t r_next;

  // ==========================================================================
  // Functions
  function automatic logic fn_level(input logic [N_IN-1:0][FN_W-1:0] map,
                                    input logic [N_IN-1:0]            pins,
                                    input logic [FN_W-1:0]            code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (map[i] == code && pins[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic out_src(input logic [FN_W-1:0] code,
                                   input logic [6:0]      cond);
    logic v;
    case (code)
      SRC_TARGET_REACHED_OUTPUT:  v = cond[0];
      SRC_FERR:   v = cond[1];
      SRC_FOLLOW: v = cond[2];
      SRC_RESP:   v = cond[3];
      SRC_JOG:    v = cond[4];
      SRC_PEND:   v = cond[5];
      SRC_FAULT:  v = cond[6];
      default:    v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Input synchronisation
  mtsio_sync_if sif ();
  assign sif.raw = {out_fault_i, base_next_i, base_home_i, card_in_i};

  mtsio_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif.filt)
  );

  logic [N_IN-1:0]   card;
  logic              base_home;
  logic              base_next;
  logic [N_OUT-1:0]  ofault;
  logic [ADDR_W-1:0] addr_vec;
  logic              lv_start;
  logic              lv_next;
  logic              lv_jog;
  logic              lv_clear;
  logic              lv_home;
  logic              start_rise;
  logic              next_rise;
  logic              jog_rise;
  logic              jog_fall;
  logic              clear_rise;
  logic [6:0]        cond;
  logic [N_OUT-1:0]  out_val;
  logic [31:0]       ctrl_wr;
  logic [31:0]       inmap1_wr;

  assign card      = sif.clean[N_IN-1:0];
  assign base_home = sif.clean[N_IN];
  assign base_next = sif.clean[N_IN+1];
  assign ofault    = sif.clean[SYNC_W-1 -: N_OUT];

  // Byte-masked write values for registers narrower than the bus
  assign ctrl_wr   = wmask({30'h0, r_reg.ctrl}, wb_dat_i, wb_sel_i);
  assign inmap1_wr = wmask({8'h00, r_reg.inmap[N_IN-1:8]}, wb_dat_i, wb_sel_i);

  // ==========================================================================
  // Function decode of inputs
  genvar g;
  generate
    for (g = 0; g < ADDR_W; g++) begin : g_addr
      assign addr_vec[g] = fn_level(r_reg.inmap, card, FN_ADDR0 + FN_W'(g));
    end
  endgenerate

  assign lv_start = fn_level(r_reg.inmap, card, FN_START);
  assign lv_next  = fn_level(r_reg.inmap, card, FN_NEXT) |
                    (r_reg.ctrl[CTRL_BASE_NEXT] & base_next);
  assign lv_jog   = fn_level(r_reg.inmap, card, FN_JOG);
  assign lv_clear = fn_level(r_reg.inmap, card, FN_CLEAR);
  assign lv_home  = fn_level(r_reg.inmap, card, FN_HOME);

  assign start_rise = lv_start & ~r_reg.p_start;
  assign next_rise  = lv_next & ~r_reg.p_next;
  assign jog_rise   = lv_jog & ~r_reg.p_jog;
  assign jog_fall   = ~lv_jog & r_reg.p_jog;
  assign clear_rise = lv_clear & ~r_reg.p_clear;

  // Internal conditions offered to the output selectors
  assign cond = {r_reg.fault, r_reg.pend, r_reg.jog_a, r_reg.rw, r_reg.fw,
                 ~ferr_outside_i, in_window_i};

  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      assign out_val[g] = out_src(r_reg.outmap[g], cond);
    end
  endgenerate

  // ==========================================================================
  // Next state
  always_comb begin
    r_next         = r_reg;
    r_next.ack     = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    r_next.dat     = '0;
    r_next.p_start = lv_start;
    r_next.p_next  = lv_next;
    r_next.p_jog   = lv_jog;
    r_next.p_clear = lv_clear;
    r_next.t_start = 1'b0;
    r_next.h_start = 1'b0;
    r_next.nxt     = 1'b0;

    // Bus slave; unmapped reads return zero and unmapped writes are dropped
    if (r_next.ack) begin
      case (wb_adr_i)
        REG_CTRL:   r_next.dat = {30'h0, r_reg.ctrl};
        REG_INMAP0: r_next.dat = r_reg.inmap[7:0];
        REG_INMAP1: r_next.dat = {8'h00, r_reg.inmap[N_IN-1:8]};
        REG_OUTMAP: r_next.dat = r_reg.outmap;
        REG_STATUS: begin
          r_next.dat[ST_CARD_LSB +: N_IN]  = card;
          r_next.dat[ST_BASE_HOME]         = base_home;
          r_next.dat[ST_BASE_NEXT]         = base_next;
          r_next.dat[ST_BLK_LSB +: ADDR_W] = r_reg.blk;
          r_next.dat[ST_FOLLOW]            = r_reg.fw;
          r_next.dat[ST_RESP]              = r_reg.rw;
          r_next.dat[ST_FAULT]             = r_reg.fault;
          r_next.dat[ST_VIOL]              = r_reg.viol;
          r_next.dat[ST_PEND]              = r_reg.pend;
          r_next.dat[ST_JOG]               = r_reg.jog_a;
        end
        default:    r_next.dat = '0;
      endcase
      if (wb_we_i) begin
        case (wb_adr_i)
          REG_CTRL: begin
            r_next.ctrl = ctrl_wr[1:0];
            if (wb_sel_i[0] && wb_dat_i[CTRL_VIOL_CLR]) begin
              r_next.viol = 1'b0;
            end
          end
          REG_INMAP0: r_next.inmap[7:0] = wmask(r_reg.inmap[7:0], wb_dat_i, wb_sel_i);
          REG_INMAP1: r_next.inmap[N_IN-1:8] = inmap1_wr[23:0];
          REG_OUTMAP: r_next.outmap = wmask(r_reg.outmap, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end
    end

    // Age of the present block number, saturating at the hold time
    if (addr_vec != r_reg.addr_prev) begin
      r_next.addr_age = '0;
    end else if (r_reg.addr_age < CNT_W'(ADDR_HOLD_CYC)) begin
      r_next.addr_age = r_reg.addr_age + CNT_W'(1);
    end
    r_next.addr_prev = addr_vec;

    // Start: the number is frozen here so later address changes are harmless
    if (start_rise) begin
      r_next.blk = addr_vec;
      if (addr_vec == '0) begin
        r_next.h_start = 1'b1;
      end else begin
        r_next.t_start = 1'b1;
      end
      // A start on a too-young number still runs; software sees the flag
      if (r_reg.addr_age < CNT_W'(ADDR_HOLD_CYC)) begin
        r_next.viol = 1'b1;
      end
    end

    // Follow-on task waits in pending until the target is reached
    if ((r_reg.pend | next_rise) & in_window_i) begin
      r_next.nxt  = 1'b1;
      r_next.pend = 1'b0;
    end else begin
      r_next.pend = r_reg.pend | next_rise;
    end

    r_next.jog_s = jog_rise;
    r_next.jog_c = jog_fall;
    r_next.jog_a = lv_jog;

    // Warning flags: a new event in the clearing cycle survives
    if (clear_rise) begin
      r_next.fw = 1'b0;
      r_next.rw = 1'b0;
    end
    if (follow_evt_i) begin
      r_next.fw = 1'b1;
    end
    if (resp_evt_i) begin
      r_next.rw = 1'b1;
    end

    r_next.home  = ~r_reg.ctrl[CTRL_BASE_HOME] & lv_home;
    r_next.fault = |ofault;
    r_next.outs  = out_val;

    // Helper counters watched by the checks below
    r_next.lat_cnt = start_rise ? CNT_W'(1) : '0;
    if (r_reg.outs != out_val && r_reg.out_lag < CNT_W'(OUT_LIMIT_CYC)) begin
      r_next.out_lag = r_reg.out_lag + CNT_W'(1);
    end else if (r_reg.outs == out_val) begin
      r_next.out_lag = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg        <= '0;
      r_reg.ctrl   <= CTRL_RST;
      r_reg.inmap  <= INMAP_RST;
      r_reg.outmap <= OUTMAP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_o       = r_reg.ack;
  assign wb_dat_o       = r_reg.dat;
  assign card_out_o     = r_reg.outs;
  assign out_fault_o    = r_reg.fault;
  assign task_start_o   = r_reg.t_start;
  assign homing_start_o = r_reg.h_start;
  assign task_num_o     = r_reg.blk;
  assign next_task_o    = r_reg.nxt;
  assign jog_start_o    = r_reg.jog_s;
  assign jog_cancel_o   = r_reg.jog_c;
  assign jog_active_o   = r_reg.jog_a;
  assign home_switch_o  = r_reg.home;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_start_go;
    start_rise ##1 (task_start_o || homing_start_o);
  endsequence

  a_bus_answer: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

  a_start_issue: assert property (start_rise |-> s_start_go)
    else $error("start not issued one cycle after request");

  a_start_latency: assert property (r_reg.lat_cnt < CNT_W'(START_LIMIT_CYC))
    else $error("start latency limit exceeded");

  a_homing_zero: assert property (start_rise && addr_vec == '0
                                  |=> homing_start_o && !task_start_o)
    else $error("homing not started for empty address");

  a_block_capture: assert property (start_rise |=> task_num_o == $past(addr_vec))
    else $error("block number not captured at start");

  a_next_waits: assert property (next_task_o |-> $past(in_window_i))
    else $error("next task started outside target window");

  a_next_held: assert property (next_rise && !in_window_i |=> r_reg.pend && !next_task_o)
    else $error("next task request not held pending");

  a_jog_edges: assert property ((jog_rise |=> jog_start_o && jog_active_o)
                                and (jog_fall |=> jog_cancel_o && !jog_active_o))
    else $error("jog edge not answered");

  a_warn_clear: assert property (clear_rise && !follow_evt_i && !resp_evt_i
                                 |=> !r_reg.fw && !r_reg.rw)
    else $error("warnings not cleared");

  a_home_gate: assert property (r_reg.ctrl[CTRL_BASE_HOME] |=> !home_switch_o)
    else $error("card home used while base home selected");

  a_fault_flag: assert property ((|ofault) |=> out_fault_o)
    else $error("output fault not flagged");

  a_out_response: assert property (r_reg.out_lag < CNT_W'(OUT_LIMIT_CYC))
    else $error("output response time exceeded");

endmodule
`default_nettype wire

// [dv/mtsio_plc.sv]
// Controller model that presents a block number and then pulses start
`timescale 1ns/1ps
`default_nettype none
module mtsio_plc #(
  parameter int unsigned HOLD = 16
) (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        rush_i,
  input  wire logic [7:0]  blk_i,
  input  wire logic [4:0]  aux_i,
  output logic      [13:0] pins_o,
  output logic             busy_o
);
  logic [7:0] addr = 8'h00;
  logic       strt = 1'b0;
  logic       busy = 1'b0;
  logic [1:0] ph   = 2'h0;
  int         cnt  = 0;
  assign busy_o = busy;
  assign pins_o = {strt, aux_i, addr};
  // Rush skips the settle time on purpose, to provoke a setup violation
  always @(posedge clk_i) begin
    if (go_i && !busy) begin
      addr   <= blk_i;
      busy   <= 1'b1;
      ph     <= 2'h0;
      cnt    <= rush_i ? 2 : HOLD + 6;
    end else if (busy) begin
      if (cnt != 0) begin
        cnt <= cnt - 1;
      end else if (ph == 2'h2) begin
        busy <= 1'b0;
      end else begin
        strt <= (ph == 2'h0);
        ph   <= ph + 2'h1;
        cnt  <= 6;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/mtsio_top_bench.sv]
// Self-checking bench for the motion task select I/O block
`timescale 1ns/1ps
`default_nettype none
module mtsio_top_bench;
  import mtsio_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, rush = 1'b0;
  logic [7:0] adr = 8'h00, blk = 8'h00, ofault = 8'h00, card_out;
  logic [4:0] aux = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic [13:0] pins;
  logic bhome = 1'b0, bnext = 1'b0, inwin = 1'b0, ferr = 1'b0, fev = 1'b0, rev = 1'b0;
  logic ack, fault, tst, hst, nxt, jst, jcn, busy, home, jact;
  logic [3:0] sel = 4'hF, wsel = 4'hF;
  logic [7:0] tnum;
  logic [10:0] exp_q[$];
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  mtsio_top #(.ADDR_HOLD_CYC(16), .START_LIMIT_CYC(8), .OUT_LIMIT_CYC(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .card_in_i(pins), .base_home_i(bhome), .base_next_i(bnext), .out_fault_i(ofault),
    .in_window_i(inwin), .ferr_outside_i(ferr), .follow_evt_i(fev), .resp_evt_i(rev),
    .card_out_o(card_out), .out_fault_o(fault), .task_start_o(tst), .homing_start_o(hst),
    .task_num_o(tnum), .next_task_o(nxt), .jog_start_o(jst), .jog_cancel_o(jcn),
    .jog_active_o(jact), .home_switch_o(home));
  mtsio_plc u_plc (.clk_i(clk_i), .go_i(go), .rush_i(rush), .blk_i(blk),
    .aux_i(aux), .pins_o(pins), .busy_o(busy));
  // ==========================================================================
  // Checking and reporting
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_evt(input logic [10:0] e, input logic [10:0] g);
    chk("event", {21'h0, e}, {21'h0, g});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // Pulses are matched in order against what the driver announced
  always @(posedge clk_i) begin
    if (!rst_i && ((tst | hst | nxt | jst | jcn) !== 1'b0)) begin
      chk_evt(exp_q.size() ? exp_q.pop_front() : 11'h7FF,
              tst ? {3'h0, tnum} : hst ? {3'h1, tnum} : nxt ? 11'h200 : jst ? 11'h300 : 11'h400);
    end
  end
  // ==========================================================================
  // Drivers
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    sel <= wsel;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
  endtask
  task automatic start(input logic [7:0] b, input logic q, input logic [10:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    blk <= b; rush <= q; go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    for (int n = 0; busy && n < 200; n++) @(posedge clk_i);
  endtask
  // ==========================================================================
  // Scenarios
  logic [7:0] b, br;
  logic [31:0] rst_tab[5] = '{32'h0, 32'h76543210, 32'h00CFBA98, 32'hFFFFFF10, 32'h0};
  initial begin
    void'($urandom(32'hb9c3));
    wait_n(12);
    rst_i <= 1'b0;
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rst_tab[i], r);
    end
    foreach (rst_tab[i]) begin
      b = (i == 0) ? 8'hAE : (i == 1) ? 8'h00 : 8'($urandom_range(1, 255));
      start(b, 1'b0, {(b == 8'h00) ? 3'h1 : 3'h0, b});
    end
    wb(1'b1, REG_INMAP0, 32'h01234567);
    b = 8'($urandom_range(1, 255));
    br = {<<{b}};
    start(b, 1'b0, {3'h0, br});
    wb(1'b1, REG_INMAP0, 32'h76543210);
    start(8'h5A, 1'b1, 11'h05A);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("violation", 32'h1, {31'h0, r[ST_VIOL]});
    // Clear bit sits in byte 0; a write without that lane must leave the flag
    wsel = {3'($urandom_range(1, 7)), 1'b0};
    wb(1'b1, REG_CTRL, 32'h4);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("violation kept", 32'h1, {31'h0, r[ST_VIOL]});
    wsel = 4'hF;
    wb(1'b1, REG_CTRL, 32'h4);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("violation clear", 32'h0, {31'h0, r[ST_VIOL]});
    aux <= 5'h04;
    wait_n(10);
    aux <= 5'h00;
    exp_q.push_back(11'h200);
    wait_n(10);
    inwin <= 1'b1;
    ferr <= 1'b1;
    wait_n(10);
    chk("outputs", 32'h1, {24'h0, card_out});
    wb(1'b1, REG_CTRL, 32'h2);
    exp_q.push_back(11'h200);
    bnext <= 1'b1;
    wait_n(10);
    bnext <= 1'b0;
    exp_q.push_back(11'h300);
    aux <= 5'h08;
    wait_n(10);
    chk("jog active", 32'h1, {31'h0, jact});
    exp_q.push_back(11'h400);
    aux <= 5'h00;
    wait_n(10);
    chk("jog idle", 32'h0, {31'h0, jact});
    fev <= 1'b1; rev <= 1'b1;
    @(posedge clk_i);
    fev <= 1'b0; rev <= 1'b0;
    wb(1'b0, REG_STATUS, 32'h0);
    chk("warnings", 32'h3, {30'h0, r[ST_RESP:ST_FOLLOW]});
    aux <= 5'h02;
    bhome <= 1'b1;
    wait_n(10);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("warnings clear", 32'h0, {30'h0, r[ST_RESP:ST_FOLLOW]});
    chk("base home", 32'h1, {31'h0, r[ST_BASE_HOME]});
    ofault <= 8'($urandom_range(1, 255));
    aux <= 5'h01;
    wait_n(8);
    chk("fault", 32'h1, {31'h0, fault});
    chk("home", 32'h1, {31'h0, home});
    ofault <= 8'h00;
    wb(1'b1, REG_CTRL, 32'h1);
    wait_n(8);
    chk("fault off", 32'h0, {31'h0, fault});
    chk("home off", 32'h0, {31'h0, home});
    chk("pending", 32'h0, exp_q.size());
    end_sim();
  end
endmodule
`default_nettype wire
